//--- verilog/mpc_pkg.sv
package mpc_pkg;

    // Timebase
    localparam int CLK_HZ = 10_000_000;
    localparam int CLK_PER_MS = CLK_HZ / 1000;

    // Pulse and sequence times in milliseconds
    localparam int ON_PULSE_MS = 1000;
    localparam int LOWV_ON_PULSE_MS = 3000;
    localparam int OFF_PULSE_MS = 1000;
    localparam int RESTART_PULSE_MS = 200;
    localparam int DETACH_TIMEOUT_MS = 100;
    localparam int BOOT_MS = 10;

    // Derived cycle counts
    localparam int ON_PULSE_CYC = ON_PULSE_MS * CLK_PER_MS;
    localparam int LOWV_ON_PULSE_CYC = LOWV_ON_PULSE_MS * CLK_PER_MS;
    localparam int OFF_PULSE_CYC = OFF_PULSE_MS * CLK_PER_MS;
    localparam int RESTART_PULSE_CYC = RESTART_PULSE_MS * CLK_PER_MS;
    localparam int DETACH_TIMEOUT_CYC = DETACH_TIMEOUT_MS * CLK_PER_MS;
    localparam int BOOT_CYC = BOOT_MS * CLK_PER_MS;

    localparam int CNT_W = 26;

    typedef enum logic [2:0] {
        MPC_OFF = 3'h0,
        MPC_BOOT = 3'h1,
        MPC_ON = 3'h2,
        MPC_DETACH = 3'h3,
        MPC_RESTART = 3'h4
    } mpc_state_t;

    // Status bundle toward the modem core
    typedef struct packed {
        logic power_on_monitor;
        logic detach_req;
        logic core_run;
        logic core_reset;
    } mpc_status_t;

endpackage

//--- verilog/mpc_power_ctrl.sv
`timescale 1ns/1ps
module mpc_power_ctrl #(
    parameter int ON_PULSE_CYC = mpc_pkg::ON_PULSE_CYC,
    parameter int LOWV_ON_PULSE_CYC = mpc_pkg::LOWV_ON_PULSE_CYC,
    parameter int OFF_PULSE_CYC = mpc_pkg::OFF_PULSE_CYC,
    parameter int RESTART_PULSE_CYC = mpc_pkg::RESTART_PULSE_CYC,
    parameter int DETACH_TIMEOUT_CYC = mpc_pkg::DETACH_TIMEOUT_CYC,
    parameter int BOOT_CYC = mpc_pkg::BOOT_CYC
) (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic power_key_n,
    input wire logic restart_n,
    input wire logic supply_low,
    input wire logic sw_off_req,
    input wire logic detach_done,
    output logic power_on_monitor,
    output logic detach_req,
    output logic core_run,
    output logic core_reset
);

    ////////////////////////////////////////////////////////////////////////
    // Constants and declarations

    localparam int PIN_CNT = 2;
    localparam int KEY_PIN = 0;
    localparam int RST_PIN = 1;
    localparam logic [mpc_pkg::CNT_W-1:0] CNT_ZERO = '0;
    localparam logic [mpc_pkg::CNT_W-1:0] CNT_ONE =
        {{(mpc_pkg::CNT_W-1){1'h0}}, 1'h1};

    logic [PIN_CNT-1:0] pin_held;
    logic [PIN_CNT-1:0] pin_release;
    logic [PIN_CNT-1:0][mpc_pkg::CNT_W-1:0] pin_cnt;
    logic [mpc_pkg::CNT_W-1:0] key_cnt;
    logic [mpc_pkg::CNT_W-1:0] rst_cnt;
    logic [mpc_pkg::CNT_W-1:0] seq_cnt;
    logic [mpc_pkg::CNT_W-1:0] next_seq_cnt;
    logic [mpc_pkg::CNT_W-1:0] on_need;
    logic key_release;
    logic rst_release;
    logic key_on_ok;
    logic key_off_ok;
    logic rst_ok;
    logic restart_go;
    logic key_off_go;
    logic key_on_go;
    logic boot_done;
    logic detach_end;
    mpc_pkg::mpc_state_t state;
    mpc_pkg::mpc_state_t next_state;
    mpc_pkg::mpc_status_t status;
    mpc_pkg::mpc_status_t next_status;

    ////////////////////////////////////////////////////////////////////////
    // Helpers

    // Counter step that stops at all ones
    function automatic logic [mpc_pkg::CNT_W-1:0] sat_inc(
        input logic [mpc_pkg::CNT_W-1:0] v
    );
        sat_inc = (&v) ? v : v + CNT_ONE;
    endfunction

    // True once a count has reached a cycle threshold
    function automatic logic reached(
        input logic [mpc_pkg::CNT_W-1:0] v,
        input int limit
    );
        reached = v >= mpc_pkg::CNT_W'(limit);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Pulse length counters, one per control pin

    assign pin_held[KEY_PIN] = !power_key_n;
    assign pin_held[RST_PIN] = !restart_n;

    genvar gi;
    generate
        for (gi = 0; gi < PIN_CNT; gi++) begin : g_pulse
            logic [mpc_pkg::CNT_W-1:0] cnt;
            logic [mpc_pkg::CNT_W-1:0] next_cnt;

            assign next_cnt = pin_held[gi] ? sat_inc(cnt) : CNT_ZERO;
            assign pin_release[gi] = !pin_held[gi] && cnt != CNT_ZERO;
            assign pin_cnt[gi] = cnt;

            always_ff @(posedge ref_clk) begin
                if (!nrst) begin
                    cnt <= CNT_ZERO;
                end else begin
                    cnt <= next_cnt;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Pulse qualification

    assign key_cnt = pin_cnt[KEY_PIN];
    assign rst_cnt = pin_cnt[RST_PIN];
    assign key_release = pin_release[KEY_PIN];
    assign rst_release = pin_release[RST_PIN];

    assign on_need = supply_low ?
        mpc_pkg::CNT_W'(LOWV_ON_PULSE_CYC) : mpc_pkg::CNT_W'(ON_PULSE_CYC);
    assign key_on_ok = key_cnt >= on_need;
    assign key_off_ok = reached(key_cnt, OFF_PULSE_CYC);
    assign rst_ok = reached(rst_cnt, RESTART_PULSE_CYC);
    assign restart_go = rst_release && rst_ok &&
        state != mpc_pkg::MPC_OFF;
    assign key_off_go = key_release && key_off_ok;
    assign key_on_go = key_release && key_on_ok;
    assign boot_done = reached(seq_cnt, BOOT_CYC);
    assign detach_end = detach_done ||
        reached(seq_cnt, DETACH_TIMEOUT_CYC);

    ////////////////////////////////////////////////////////////////////////
    // Power sequence

    always_comb begin
        next_state = state;
        next_seq_cnt = sat_inc(seq_cnt);
        unique case (state)
            mpc_pkg::MPC_OFF: begin
                if (key_on_go) begin
                    next_state = mpc_pkg::MPC_BOOT;
                    next_seq_cnt = CNT_ZERO;
                end
            end
            mpc_pkg::MPC_BOOT, mpc_pkg::MPC_RESTART: begin
                if (restart_go) begin
                    next_state = mpc_pkg::MPC_RESTART;
                    next_seq_cnt = CNT_ZERO;
                end else if (boot_done) begin
                    next_state = mpc_pkg::MPC_ON;
                end
            end
            mpc_pkg::MPC_ON: begin
                if (restart_go) begin
                    next_state = mpc_pkg::MPC_RESTART;
                    next_seq_cnt = CNT_ZERO;
                end else if (key_off_go || sw_off_req) begin
                    next_state = mpc_pkg::MPC_DETACH;
                    next_seq_cnt = CNT_ZERO;
                end
            end
            mpc_pkg::MPC_DETACH: begin
                if (restart_go) begin
                    next_state = mpc_pkg::MPC_RESTART;
                    next_seq_cnt = CNT_ZERO;
                end else if (detach_end) begin
                    next_state = mpc_pkg::MPC_OFF;
                end
            end
            default: begin
                next_state = mpc_pkg::MPC_OFF;
            end
        endcase
    end

    // Outputs follow the next state so they change with it
    always_comb begin
        next_status.power_on_monitor =
            next_state != mpc_pkg::MPC_OFF;
        next_status.detach_req =
            next_state == mpc_pkg::MPC_DETACH;
        next_status.core_run = next_state == mpc_pkg::MPC_ON ||
            next_state == mpc_pkg::MPC_DETACH;
        next_status.core_reset = next_state == mpc_pkg::MPC_BOOT ||
            next_state == mpc_pkg::MPC_RESTART;
    end

    ////////////////////////////////////////////////////////////////////////
    // State and output registers

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            state <= mpc_pkg::MPC_OFF;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            seq_cnt <= CNT_ZERO;
        end else begin
            seq_cnt <= next_seq_cnt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            status <= '0;
        end else begin
            status <= next_status;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign power_on_monitor = status.power_on_monitor;
    assign detach_req = status.detach_req;
    assign core_run = status.core_run;
    assign core_reset = status.core_reset;

endmodule // mpc_power_ctrl

//--- testbench/mpc_chk.sv
`timescale 1ns/1ps
module mpc_chk (
    input wire logic ref_clk,
    input wire logic nrst,
    input wire logic power_key_n,
    input wire logic sw_off_req,
    input wire logic power_on_monitor,
    input wire logic detach_req,
    input wire logic core_run,
    input wire logic core_reset
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    sequence s_detach_end;
        detach_req ##1 (!detach_req && !core_reset);
    endsequence
    AST_OFF_AFTER_RELEASE: assert property ($rose(detach_req) |->
        $past(power_key_n) || $past(sw_off_req)) else $error("early off");
    AST_DETACH_FIRST: assert property ($fell(core_run) && !core_reset
        |-> $past(detach_req)) else $error("off without detach");
    AST_MON_LOW: assert property (s_detach_end |->
        !power_on_monitor && !core_run) else $error("monitor still high");
    AST_RESTART_NO_DETACH: assert property ($rose(core_reset)
        && $past(power_on_monitor) |-> !detach_req && !core_run)
        else $error("restart with detach");
    AST_MON_RISE: assert property ($rose(power_on_monitor) |->
        core_reset && !core_run) else $error("bad turn on");
    AST_KEY_LOW: assert property ($rose(power_on_monitor) |->
        $past(power_key_n) && !$past(power_key_n, 2)) else $error("key level");
endmodule // mpc_chk
bind mpc_power_ctrl mpc_chk mpc_chk_i(.ref_clk(ref_clk), .nrst(nrst),
    .power_key_n(power_key_n), .sw_off_req(sw_off_req),
    .power_on_monitor(power_on_monitor), .detach_req(detach_req),
    .core_run(core_run), .core_reset(core_reset));

//--- testbench/mpc_host.sv
`timescale 1ns/1ps
module mpc_host (
    input wire logic ref_clk,
    output logic power_key_n,
    output logic restart_n
);
    initial begin
        power_key_n = 1'b1; // Released lines sit at pull-up
        restart_n = 1'b1;
    end
    // One timed low pulse at a time
    task automatic pulse(input bit rst, input int n);
        @(negedge ref_clk);
        if (rst) restart_n = 1'b0;
        else power_key_n = 1'b0;
        repeat (n) @(negedge ref_clk);
        power_key_n = 1'b1;
        restart_n = 1'b1;
    endtask
endmodule // mpc_host

//--- testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic ref_clk = 1'b0;
    logic nrst = 1'b0;
    logic supply_low = 1'b0;
    logic sw_off_req = 1'b0;
    logic detach_done = 1'b0;
    wire power_key_n, restart_n, power_on_monitor, detach_req, core_run;
    wire core_reset;
    int mismatches = 0;
    int total_checks = 0;
    always #50 ref_clk = ~ref_clk;
    mpc_host mpc_host_i(.ref_clk, .power_key_n, .restart_n);
    mpc_power_ctrl #(.ON_PULSE_CYC(20), .LOWV_ON_PULSE_CYC(60),
        .OFF_PULSE_CYC(20), .DETACH_TIMEOUT_CYC(10),
        .BOOT_CYC(5)) mpc_power_ctrl_i(.ref_clk, .nrst, .power_key_n,
        .restart_n, .supply_low, .sw_off_req, .detach_done,
        .power_on_monitor, .detach_req, .core_run, .core_reset);
    task automatic chk(input string n, input logic e, input logic v);
        total_checks++;
        if (v !== e) begin
            mismatches++;
            $display("mismatch %s expected %b seen %b", n, e, v);
        end
    endtask
    task automatic settle(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic t_on_off;
        mpc_host_i.pulse(0, 20);
        settle(2);
        chk("mon", 1'b1, power_on_monitor);
        settle(7);
        chk("run", 1'b1, core_run);
        mpc_host_i.pulse(0, 19);
        settle(3);
        chk("short", 1'b0, detach_req);
        mpc_host_i.pulse(0, 20);
        settle(2);
        chk("det", 1'b1, detach_req);
        detach_done = 1'b1;
        settle(2);
        detach_done = 1'b0;
        chk("off", 1'b0, power_on_monitor);
    endtask
    task automatic t_lowv_restart;
        supply_low = 1'b1;
        mpc_host_i.pulse(0, 20);
        settle(2);
        chk("lowv", 1'b0, power_on_monitor);
        mpc_host_i.pulse(0, 60);
        settle(9);
        chk("lvon", 1'b1, core_run);
        supply_low = 1'b0;
        mpc_host_i.pulse(1, mpc_pkg::RESTART_PULSE_CYC - 1);
        settle(2);
        chk("rshort", 1'b0, core_reset);
        mpc_host_i.pulse(1, mpc_pkg::RESTART_PULSE_CYC);
        settle(2);
        chk("rst", 1'b1, core_reset);
        chk("rdet", 1'b0, detach_req);
        chk("rmon", 1'b1, power_on_monitor);
        settle(8);
    endtask
    task automatic t_sw_off;
        sw_off_req = 1'b1;
        settle(1);
        sw_off_req = 1'b0;
        settle(1);
        chk("swdet", 1'b1, detach_req);
        settle(14);
        chk("swoff", 1'b0, power_on_monitor);
    endtask
    initial begin
        settle(5);
        nrst = 1'b1;
        settle(1);
        t_on_off();
        t_lowv_restart();
        t_sw_off();
        results();
    end
endmodule // tb_top
